// ===== core/cssr_pkg.sv
// Purpose: Constants for the core special status register block
// Assumes: 32-bit data, registers selected by a special register code
// Notes:   Selector codes index the special move instructions
package cssr_pkg;

  // Special register selectors used by the move instructions
  localparam logic [2:0] SEL_COND_FLAGS  = 3'h0;
  localparam logic [2:0] SEL_COND_EXCNUM = 3'h1;
  localparam logic [2:0] SEL_EXEC_STATE  = 3'h2;
  localparam logic [2:0] SEL_COND_EXEC   = 3'h3;
  localparam logic [2:0] SEL_FULL_STATUS = 3'h4;
  localparam logic [2:0] SEL_EXCNUM_EXEC = 3'h5;
  localparam logic [2:0] SEL_PRIO_MASK   = 3'h6;
  localparam logic [2:0] SEL_STACK_CTRL  = 3'h7;

  // Field positions
  localparam int FLAG_N_POS   = 31;
  localparam int FLAG_V_POS   = 28;
  localparam int EXC_MSB      = 5;
  localparam int ISET_POS     = 24;
  localparam int PMASK_POS    = 0;
  localparam int SPSEL_POS    = 1;

  // Reset values
  localparam logic [3:0] FLAGS_RST  = 4'h0;
  localparam logic [5:0] EXC_RST    = 6'h00;
  localparam logic       PMASK_RST  = 1'b0;
  localparam logic       SPSEL_RST  = 1'b0;

  // Exception numbers
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam logic [5:0] EXC_NMI    = 6'h02;
  localparam logic [5:0] EXC_HFAULT = 6'h03;
  localparam logic [5:0] EXC_SVC    = 6'h0B;
  localparam logic [5:0] EXC_PEND_SERVICE = 6'h0E;
  localparam logic [5:0] EXC_TICK   = 6'h0F;
  localparam logic [5:0] EXC_IRQ0   = 6'h10;
  localparam logic [5:0] EXC_IRQ31  = 6'h2F;

  // Access size codes
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_HALF  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;

  // Multi-word transfer sequencer states, Gray along the usual path
  typedef enum logic [1:0] {
    MW_IDLE    = 2'b00,
    MW_RUN     = 2'b01,
    MW_ABORTED = 2'b11
  } cssr_mw_state_t;

endpackage

// ===== core/cssr_lane.sv
// Purpose: Little-endian byte lane steering for data accesses
// Assumes: Naturally aligned accesses
// Notes:   Combinational; the top registers its results
`timescale 1ns/1ps
`default_nettype none
module cssr_lane
  import cssr_pkg::*;
(
  input  wire logic [1:0]  size_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] rbus_i,
  output logic      [3:0]  strb_o,
  output logic      [31:0] wbus_o,
  output logic      [31:0] rdata_o
);

  logic [4:0] sh;
  assign sh = {addr_i, 3'b000};

  always_comb begin
    strb_o  = 4'h0;
    wbus_o  = 32'h0000_0000;
    rdata_o = 32'h0000_0000;
    if (size_i == SIZE_BYTE) begin
      strb_o  = 4'h1 << addr_i;
      wbus_o  = {24'h00_0000, wdata_i[7:0]} << sh;
      rdata_o = {24'h00_0000, 8'(rbus_i >> sh)};
    end else if (size_i == SIZE_HALF) begin
      strb_o  = 4'h3 << {addr_i[1], 1'b0};
      wbus_o  = {16'h0000, wdata_i[15:0]} << {addr_i[1], 4'h0};
      rdata_o = {16'h0000, 16'(rbus_i >> {addr_i[1], 4'h0})};
    end else begin
      strb_o  = 4'hF;
      wbus_o  = wdata_i;
      rdata_o = rbus_i;
    end
  end

endmodule
`default_nettype wire

// ===== core/cssr_top.sv
// Purpose: Special status registers of a small 32-bit core
// Assumes: Driven by the core's decode and exception sequencer on clk_i
// Notes:   One access per cycle; read data registered one cycle later
//
// What this block does
// - Flags N Z C V in bits 31..28
// - Exception number in bits 5..0
// - Exception numbers encode fixed exception kinds
// - Instruction-set state bit at position 24
// - Execution state reads zero, writes ignored
// - Branch, return or vector can clear it
// - Executing with state zero raises fault
// - Interrupted multi-word transfer restarts from start
// - Priority mask bit blocks configurable exceptions
// - Mask set by moves or state change
// - Thread mode control bit 1 selects stack
// - Handler mode: main stack, bit reads zero
// - Entry and return update control register
// - Every exception except reset uses handler mode
// - Byte, half, word accesses, little-endian
// - Combined-view writes skip exception number
// - Reset loads state bit from vector
`timescale 1ns/1ps
`default_nettype none
module cssr_top
  import cssr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Special move port
  input  wire logic        mts_i,
  input  wire logic        mfs_i,
  input  wire logic [2:0]  sel_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  // Change-processor-state
  input  wire logic        state_chg_i,
  input  wire logic        state_chg_dis_i,
  // Flag update from the ALU
  input  wire logic        flags_we_i,
  input  wire logic [3:0]  flags_i,
  // Reset vector bit 0, valid on the first cycle after reset
  input  wire logic        rst_vec_lsb_i,
  // Branch exchange / pop into PC
  input  wire logic        brx_i,
  input  wire logic        brx_lsb_i,
  // Exception entry and return
  input  wire logic        exc_entry_i,
  input  wire logic [5:0]  exc_num_i,
  input  wire logic        vec_lsb_i,
  input  wire logic        exc_return_i,
  input  wire logic [31:0] stacked_psr_i,
  input  wire logic [5:0]  ret_num_i,
  input  wire logic        ret_spsel_i,
  // Instruction issue and multi-word transfers
  input  wire logic        exec_i,
  input  wire logic        mw_start_i,
  input  wire logic        mw_beat_i,
  input  wire logic        mw_last_i,
  input  wire logic        irq_take_i,
  // Data access lane steering
  input  wire logic        dacc_i,
  input  wire logic [1:0]  dsize_i,
  input  wire logic [1:0]  daddr_i,
  input  wire logic [31:0] dwdata_i,
  input  wire logic [31:0] drbus_i,
  output logic      [3:0]  dstrb_o,
  output logic      [31:0] dwbus_o,
  output logic      [31:0] drdata_o,
  // Status outputs
  output logic      [3:0]  flags_o,
  output logic      [5:0]  exc_num_o,
  output logic             handler_mode_o,
  output logic             use_process_stack_o,
  output logic             prio_block_o,
  output logic             iset_fault_o,
  output logic             mw_restart_o,
  output logic      [3:0]  mw_restart_idx_o
);

  logic [3:0]     flags_q;
  logic [5:0]     exc_q;
  logic           iset_q;
  logic           pmask_q;
  logic           spsel_q;
  logic           first_q;
  logic           fault_q;
  logic [31:0]    rdata_q;
  cssr_mw_state_t mw_q;
  logic [3:0]     mw_idx_q;
  logic           restart_q;
  logic [3:0]     strb_q;
  logic [31:0]    wbus_q;
  logic [31:0]    drd_q;
  logic           spsel_d;
  logic           handler_d;
  logic           handler_q;
  logic           ups_q;

  logic           handler;
  logic           wr_flags;
  logic           psr_view;
  assign handler  = (exc_q != EXC_THREAD);
  assign psr_view = (sel_i == SEL_FULL_STATUS) || (sel_i == SEL_COND_EXCNUM) || (sel_i == SEL_COND_EXEC);
  assign wr_flags = mts_i && ((sel_i == SEL_COND_FLAGS) || psr_view);

  // Condition flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RST;
    end else if (exc_return_i) begin
      flags_q <= stacked_psr_i[FLAG_N_POS:FLAG_V_POS];
    end else if (wr_flags) begin
      flags_q <= wdata_i[FLAG_N_POS:FLAG_V_POS];
    end else if (flags_we_i) begin
      flags_q <= flags_i;
    end
  end

  // Active exception number; software writes never reach it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_q <= EXC_RST;
    end else if (exc_entry_i) begin
      exc_q <= exc_num_i;
    end else if (exc_return_i) begin
      exc_q <= ret_num_i;
    end
  end

  // Instruction-set state bit; move writes have no path here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_q <= 1'b1;
      iset_q  <= 1'b0;
    end else begin
      first_q <= 1'b0;
      if (first_q) begin
        iset_q <= rst_vec_lsb_i;
      end else if (exc_entry_i) begin
        iset_q <= vec_lsb_i;
      end else if (exc_return_i) begin
        iset_q <= stacked_psr_i[ISET_POS];
      end else if (brx_i) begin
        iset_q <= brx_lsb_i;
      end
    end
  end

  // Fault request when executing with the state bit clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= exec_i && !iset_q && !first_q;
    end
  end

  // Priority mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmask_q <= PMASK_RST;
    end else if (state_chg_i) begin
      pmask_q <= state_chg_dis_i;
    end else if (mts_i && sel_i == SEL_PRIO_MASK) begin
      pmask_q <= wdata_i[PMASK_POS];
    end
  end

  // Stack select control: next value shared by the register and the output flop
  always_comb begin
    spsel_d = spsel_q;
    if (exc_entry_i) begin
      spsel_d = 1'b0;
    end else if (exc_return_i) begin
      spsel_d = ret_spsel_i;
    end else if (mts_i && sel_i == SEL_STACK_CTRL && !handler) begin
      spsel_d = wdata_i[SPSEL_POS];
    end
  end

  always_comb begin
    handler_d = handler;
    if (exc_entry_i) begin
      handler_d = (exc_num_i != EXC_THREAD);
    end else if (exc_return_i) begin
      handler_d = (ret_num_i != EXC_THREAD);
    end
  end

  // Mode outputs come from flops that track the exception number
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spsel_q   <= SPSEL_RST;
      handler_q <= 1'b0;
      ups_q     <= 1'b0;
    end else begin
      spsel_q   <= spsel_d;
      handler_q <= handler_d;
      ups_q     <= spsel_d && !handler_d;
    end
  end

  // Read mux: reserved bits and execution state read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (mfs_i) begin
      rdata_q <= 32'h0000_0000;
      if (sel_i == SEL_COND_FLAGS || psr_view) begin
        rdata_q[FLAG_N_POS:FLAG_V_POS] <= flags_q;
      end
      if (sel_i == SEL_COND_EXCNUM || sel_i == SEL_FULL_STATUS || sel_i == SEL_EXCNUM_EXEC) begin
        rdata_q[EXC_MSB:0] <= exc_q;
      end
      if (sel_i == SEL_PRIO_MASK) begin
        rdata_q[PMASK_POS] <= pmask_q;
      end
      if (sel_i == SEL_STACK_CTRL) begin
        rdata_q[SPSEL_POS] <= spsel_q && !handler;
      end
    end
  end

  // Multi-word transfer tracking and restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mw_q      <= MW_IDLE;
      mw_idx_q  <= 4'h0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      case (mw_q)
        MW_IDLE: begin
          if (mw_start_i) begin
            mw_q     <= MW_RUN;
            mw_idx_q <= 4'h0;
          end
        end
        MW_RUN: begin
          if (irq_take_i) begin
            mw_q     <= MW_ABORTED;
            mw_idx_q <= 4'h0;
          end else if (mw_beat_i && mw_last_i) begin
            mw_q <= MW_IDLE;
          end else if (mw_beat_i) begin
            mw_idx_q <= mw_idx_q + 4'h1;
          end
        end
        MW_ABORTED: begin
          if (exc_return_i) begin
            mw_q      <= MW_IDLE;
            restart_q <= 1'b1;
          end
        end
        default: mw_q <= MW_IDLE;
      endcase
    end
  end

  // Little-endian lane steering
  logic [3:0]  strb_c;
  logic [31:0] wbus_c;
  logic [31:0] drd_c;

  cssr_lane u_lane (
    .size_i  (dsize_i),
    .addr_i  (daddr_i),
    .wdata_i (dwdata_i),
    .rbus_i  (drbus_i),
    .strb_o  (strb_c),
    .wbus_o  (wbus_c),
    .rdata_o (drd_c)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strb_q <= 4'h0;
      wbus_q <= 32'h0000_0000;
      drd_q  <= 32'h0000_0000;
    end else begin
      strb_q <= dacc_i ? strb_c : 4'h0;
      wbus_q <= wbus_c;
      drd_q  <= drd_c;
    end
  end

  assign rdata_o             = rdata_q;
  assign flags_o             = flags_q;
  assign exc_num_o           = exc_q;
  assign handler_mode_o      = handler_q;
  assign use_process_stack_o = ups_q;
  assign prio_block_o        = pmask_q;
  assign iset_fault_o        = fault_q;
  assign mw_restart_o        = restart_q;
  assign mw_restart_idx_o    = mw_idx_q;
  assign dstrb_o             = strb_q;
  assign dwbus_o             = wbus_q;
  assign drdata_o            = drd_q;

  // Assertions
  a_exc_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (mts_i && !exc_entry_i && !exc_return_i) |=> $stable(exc_q))
    else $error("exception number changed by a move");
  a_exec_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (mfs_i && sel_i == SEL_EXEC_STATE) |=> rdata_o == 32'h0000_0000)
    else $error("execution state read not zero");
  a_handler_sp_main: assert property (@(posedge clk_i) disable iff (rst_i)
    handler |-> !use_process_stack_o)
    else $error("process stack used in handler mode");
  a_entry_main_stack: assert property (@(posedge clk_i) disable iff (rst_i)
    exc_entry_i |=> !spsel_q)
    else $error("entry did not clear stack select");
  a_iset_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    (exec_i && !iset_q && !first_q) |=> iset_fault_o)
    else $error("no fault on execute with state clear");
  a_branch_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (brx_i && !brx_lsb_i && !first_q && !exc_entry_i && !exc_return_i) |=> !iset_q)
    else $error("branch did not clear state bit");
  a_chg_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    state_chg_i |=> prio_block_o == $past(state_chg_dis_i))
    else $error("state change did not update mask");
  a_mw_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (mw_q == MW_ABORTED && exc_return_i) |=> (mw_restart_o && mw_restart_idx_o == 4'h0))
    else $error("multi-word restart missing");
  a_flags_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_flags && !exc_return_i) |=> flags_o == $past(wdata_i[31:28]))
    else $error("flag write lost");
  a_word_lanes: assert property (@(posedge clk_i) disable iff (rst_i)
    (dacc_i && dsize_i == SIZE_WORD) |=> dstrb_o == 4'hF)
    else $error("word access lanes wrong");
  a_stack_write_handler: assert property (@(posedge clk_i) disable iff (rst_i)
    (mts_i && sel_i == SEL_STACK_CTRL && handler && !exc_entry_i && !exc_return_i) |=> $stable(spsel_q))
    else $error("stack select written in handler mode");
  a_exec_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (mts_i && sel_i == SEL_EXEC_STATE && !first_q && !exc_entry_i && !exc_return_i && !brx_i) |=> $stable(iset_q))
    else $error("execution state changed by a move");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    mfs_i |=> rdata_o[27:6] == '0)
    else $error("reserved read bits not zero");
  a_reset_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    first_q |=> iset_q == $past(rst_vec_lsb_i))
    else $error("state bit not loaded from reset vector");

endmodule
`default_nettype wire

// ===== dv/cssr_tb.sv
// Purpose: Self-checking bench for the special status register block
// Assumes: Requests on the falling edge, results one cycle after the edge
// Notes:   Read and lane results are queued by the driver, popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cssr_pkg::*;
;
  logic        clk_i, rst_i, mts_i, mfs_i, state_chg_i, state_chg_dis_i, flags_we_i, rst_vec_lsb_i, brx_i, brx_lsb_i;
  logic        exc_entry_i, vec_lsb_i, exc_return_i, ret_spsel_i, exec_i, mw_start_i, mw_beat_i;
  logic        mw_last_i, irq_take_i, dacc_i, handler_mode_o, use_process_stack_o, prio_block_o;
  logic        iset_fault_o, mw_restart_o, tk_rd, tk_ln;
  logic [1:0]  dsize_i, daddr_i, s, a;
  logic [2:0]  sel_i;
  logic [3:0]  flags_i, dstrb_o, flags_o, mw_restart_idx_o, fl, sb, r;
  logic [5:0]  exc_num_i, ret_num_i, exc_num_o;
  logic [31:0] wdata_i, stacked_psr_i, dwdata_i, drbus_i, rdata_o, dwbus_o, drdata_o, wd, rb, rx, ew, m;
  logic [67:0] e;
  logic [31:0] rq[$];
  logic [67:0] lq[$];
  logic [5:0]  codes[7] = '{EXC_NMI, EXC_HFAULT, EXC_SVC, EXC_PEND_SERVICE, EXC_TICK, EXC_IRQ0, EXC_IRQ31};
  int          num_errors, n_compared;

  cssr_top DUT (
    .clk_i, .rst_i, .mts_i, .mfs_i, .sel_i, .wdata_i, .rdata_o, .state_chg_i, .state_chg_dis_i, .flags_we_i,
    .flags_i, .rst_vec_lsb_i, .brx_i, .brx_lsb_i, .exc_entry_i, .exc_num_i, .vec_lsb_i, .exc_return_i,
    .stacked_psr_i, .ret_num_i, .ret_spsel_i, .exec_i, .mw_start_i, .mw_beat_i, .mw_last_i, .irq_take_i,
    .dacc_i, .dsize_i, .daddr_i, .dwdata_i, .drbus_i, .dstrb_o, .dwbus_o, .drdata_o, .flags_o, .exc_num_o,
    .handler_mode_o, .use_process_stack_o, .prio_block_o, .iset_fault_o, .mw_restart_o, .mw_restart_idx_o
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Monitor: results are checked on the falling edge after the rising edge that took the request
  always @(posedge clk_i) begin
    tk_rd <= mfs_i;
    tk_ln <= dacc_i;
  end
  always @(negedge clk_i) begin
    if (tk_rd) begin
      check(rdata_o, rq.pop_front(), "read data");
    end
    if (tk_ln) begin
      e = lq.pop_front();
      m = {{8{e[67]}}, {8{e[66]}}, {8{e[65]}}, {8{e[64]}}};
      check(dstrb_o, e[67:64], "strobes");
      check(drdata_o, e[63:32], "lane read");
      check(dwbus_o & m, e[31:0] & m, "lane write");
    end
  end

  task automatic idle();
    @(negedge clk_i);
    {mts_i, mfs_i, state_chg_i, flags_we_i, brx_i, exc_entry_i, exc_return_i, exec_i} = '0;
    {mw_start_i, mw_beat_i, mw_last_i, irq_take_i, dacc_i} = '0;
  endtask

  task automatic mv(input logic w, input logic [2:0] sl, input logic [31:0] d);
    mts_i = w;
    mfs_i = !w;
    sel_i = sl;
    wdata_i = d;
    idle();
  endtask

  task automatic rd(input logic [2:0] sl, input logic [31:0] x);
    rq.push_back(x);
    mv(1'b0, sl, 32'h0000_0000);
  endtask

  task automatic st(input logic [5:0] x, input logic h, input logic u, input logic p);
    check(flags_o, fl, "flags");
    check(exc_num_o, x, "exception number");
    check(handler_mode_o, h, "handler mode");
    check(use_process_stack_o, u, "process stack");
    check(prio_block_o, p, "priority block");
  endtask

  task automatic exe(input logic f);
    exec_i = 1'b1;
    idle();
    check(iset_fault_o, f, "state fault");
  endtask

  task automatic ent(input logic [5:0] n, input logic v);
    exc_entry_i = 1'b1;
    exc_num_i = n;
    vec_lsb_i = v;
    idle();
  endtask

  task automatic ret(input logic [31:0] psr, input logic sp);
    exc_return_i = 1'b1;
    stacked_psr_i = psr;
    ret_num_i = EXC_THREAD;
    ret_spsel_i = sp;
    fl = psr[31:28];
    idle();
  endtask

  task automatic reset(input logic v);
    rst_i = 1'b1;
    rst_vec_lsb_i = v;
    repeat (6) idle();
    rst_i = 1'b0;
    idle();
    fl = 4'h0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    {mts_i, mfs_i, state_chg_i, state_chg_dis_i, flags_we_i, brx_i, brx_lsb_i, exc_entry_i, vec_lsb_i, exc_return_i} = '0;
    {ret_spsel_i, exec_i, mw_start_i, mw_beat_i, mw_last_i, irq_take_i, dacc_i, dsize_i, daddr_i, sel_i} = '0;
    {flags_i, exc_num_i, ret_num_i, wdata_i, stacked_psr_i, dwdata_i, drbus_i} = '0;
    rst_i = 1'b1;
    rst_vec_lsb_i = 1'b1;
    void'($urandom(32'h763036fd));
    reset(1'b1);
    st(EXC_THREAD, 1'b0, 1'b0, 1'b0);
    exe(1'b0);
    // Flags, reserved bits, read-as-zero execution state
    mv(1'b1, SEL_COND_FLAGS, 32'hFFFF_FFFF);
    fl = 4'hF;
    rd(SEL_COND_FLAGS, 32'hF000_0000);
    rd(SEL_EXEC_STATE, 32'h0000_0000);
    mv(1'b1, SEL_EXEC_STATE, 32'hFFFF_FFFF);
    rd(SEL_FULL_STATUS, 32'hF000_0000);
    r = 4'($urandom);
    flags_we_i = 1'b1;
    flags_i = r;
    mv(1'b1, SEL_COND_FLAGS, {~r, 28'h0});
    fl = ~r;
    st(EXC_THREAD, 1'b0, 1'b0, 1'b0);
    flags_we_i = 1'b1;
    idle();
    fl = r;
    rd(SEL_COND_EXEC, {r, 28'h0});
    // Priority mask through moves and state change
    mv(1'b1, SEL_PRIO_MASK, 32'hFFFF_FFFF);
    rd(SEL_PRIO_MASK, 32'h0000_0001);
    check(prio_block_o, 1'b1, "mask set");
    state_chg_i = 1'b1;
    mv(1'b1, SEL_PRIO_MASK, 32'h0000_0001);
    check(prio_block_o, 1'b0, "state change clear");
    state_chg_i = 1'b1;
    state_chg_dis_i = 1'b1;
    idle();
    rd(SEL_PRIO_MASK, 32'h0000_0001);
    mv(1'b1, SEL_PRIO_MASK, 32'hFFFF_FFFE);
    check(prio_block_o, 1'b0, "mask clear");
    // Stack select across entry and return for every exception kind
    foreach (codes[i]) begin
      mv(1'b1, SEL_STACK_CTRL, 32'hFFFF_FFFF);
      rd(SEL_STACK_CTRL, 32'h0000_0002);
      check(use_process_stack_o, 1'b1, "process stack");
      ent(codes[i], 1'b1);
      st(codes[i], 1'b1, 1'b0, 1'b0);
      mv(1'b1, SEL_STACK_CTRL, 32'h0000_0002);
      rd(SEL_STACK_CTRL, 32'h0000_0000);
      rd(SEL_EXCNUM_EXEC, {26'h0, codes[i]});
      mv(1'b1, SEL_COND_EXCNUM, 32'hA000_003F);
      fl = 4'hA;
      rd(SEL_COND_EXCNUM, {4'hA, 22'h0, codes[i]});
      ret(32'h5100_0000, 1'b1);
      st(EXC_THREAD, 1'b0, 1'b1, 1'b0);
      exe(1'b0);
    end
    // Each source that clears the state bit
    brx_i = 1'b1;
    idle();
    exe(1'b1);
    idle();
    check(iset_fault_o, 1'b0, "fault pulse");
    brx_i = 1'b1;
    brx_lsb_i = 1'b1;
    idle();
    exe(1'b0);
    ent(EXC_HFAULT, 1'b0);
    exe(1'b1);
    ent(EXC_SVC, 1'b1);
    exe(1'b0);
    ret(32'h0000_0000, 1'b0);
    exe(1'b1);
    brx_i = 1'b1;
    idle();
    // Interrupted multi-word transfer restarts, clean one does not
    mw_start_i = 1'b1;
    idle();
    mw_beat_i = 1'b1;
    idle();
    mw_beat_i = 1'b1;
    irq_take_i = 1'b1;
    idle();
    ent(EXC_IRQ0, 1'b1);
    ret(32'h0100_0000, 1'b0);
    check(mw_restart_o, 1'b1, "restart");
    check(mw_restart_idx_o, 4'h0, "restart index");
    idle();
    check(mw_restart_o, 1'b0, "restart pulse");
    mw_start_i = 1'b1;
    idle();
    mw_beat_i = 1'b1;
    mw_last_i = 1'b1;
    idle();
    ent(EXC_IRQ0, 1'b1);
    ret(32'h0100_0000, 1'b0);
    check(mw_restart_o, 1'b0, "no restart");
    // Little-endian lanes for random sizes and addresses
    repeat (24) begin
      s = 2'($urandom_range(2, 0));
      a = 2'($urandom_range(3, 0));
      a = (s == SIZE_WORD) ? 2'h0 : (s == SIZE_HALF) ? (a & 2'h2) : a;
      wd = $urandom;
      rb = $urandom;
      sb = (s == SIZE_BYTE) ? 4'h1 << a : (s == SIZE_HALF) ? 4'h3 << a : 4'hF;
      rx = (s == SIZE_WORD) ? rb : (rb >> (8 * a)) & ((s == SIZE_BYTE) ? 32'h0000_00FF : 32'h0000_FFFF);
      ew = wd << (8 * a);
      lq.push_back({sb, rx, ew});
      {dacc_i, dsize_i, daddr_i, dwdata_i, drbus_i} = {1'b1, s, a, wd, rb};
      idle();
    end
    // Reset in mid-run with a cleared vector bit
    mv(1'b1, SEL_PRIO_MASK, 32'h0000_0001);
    reset(1'b0);
    st(EXC_THREAD, 1'b0, 1'b0, 1'b0);
    exe(1'b1);
    reset(1'b1);
    exe(1'b0);
    idle();
    check(32'(rq.size() + lq.size()), 32'h0, "pending results");
    print_verdict();
  end
endmodule
`default_nettype wire
